// ===== shared/ser_tx_pkg.sv
/*
  Constants shared by the 10-bit serializer transmit control block.
  Assumes a 10 MHz system clock sampling the transmit clock pin.
*/
package ser_tx_pkg;
  localparam int unsigned DATA_W       = 10;
  localparam int unsigned FRAME_W      = 12;
  localparam int unsigned SYNC_W       = 16;
  // positions inside the synchroniser vector
  localparam int unsigned POS_DATA     = 0;
  localparam int unsigned POS_TX_CLK   = 10;
  localparam int unsigned POS_EDGE_SEL = 11;
  localparam int unsigned POS_LINE_EN  = 12;
  localparam int unsigned POS_SLEEP_N  = 13;
  localparam int unsigned POS_SYNC_A   = 14;
  localparam int unsigned POS_SYNC_B   = 15;
  // frame layout
  localparam logic        CLK_HIGH_BIT = 1'b1;
  localparam logic        CLK_LOW_BIT  = 1'b0;
  localparam logic [3:0]  LAST_SLOT    = 4'hb;
  localparam logic [9:0]  SYNC_WORD    = 10'h01f;
  localparam logic [10:0] SYNC_MIN     = 11'h400;
  localparam logic [9:0]  HOLD_RESET   = 10'h000;
  localparam logic [11:0] FRAME_RESET  = 12'h000;
  typedef enum logic [1:0] {ST_SLEEP, ST_IDLE, ST_FRAME} tx_state_t;
endpackage : ser_tx_pkg

// ===== src/ser_tx_control.sv
/*
  Transmit control of a 10-bit serializer: captures the parallel word on the
  selected transmit clock edge and sends 12-slot frames, or sync symbols.
  Assumes all pins are asynchronous to sys_clk_in and pass a synchroniser;
  the serial pair is tri-stated outside from serial_oe_out; the testbench only feeds it to ser_rx_model.
*/
//
// Contract
// - capture parallel word into 10-bit holding register on active edge; serialize it
// - edge select high picks rising, low picks falling transmit clock edge
// - line drive enable low puts both serial outputs in high impedance
// - sleep low stops multiplier, tri-states outputs, enters sleep
// - stay disabled while sleep low; resume only when driven high
// - sync request rise sends at least 1024 sync symbols before data
// - sync symbols continue while sync request stays asserted
// - the two sync request inputs are ORed
// - positive output carries the bit, negative output its complement
// - two embedded clock bits accompany each 10-bit word
// - sleep low then high resets multiplier and recovers normal operation
`timescale 1ns/1ns
`default_nettype none
module ser_tx_control
  import ser_tx_pkg::*;
(
  // clock and reset
  input  wire logic                         sys_clk_in,
  input  wire logic                         sys_rst_in,
  // parallel side
  input  wire logic [ser_tx_pkg::DATA_W-1:0] parallel_data_in,
  input  wire logic                         transmit_clock_in,
  input  wire logic                         capture_edge_select_in,
  // control pins
  input  wire logic                         line_drive_enable_in,
  input  wire logic                         sleep_n_in,
  input  wire logic                         sync_request_a_in,
  input  wire logic                         sync_request_b_in,
  // serial pair
  output logic                              serial_p_out,
  output logic                              serial_n_out,
  output logic                              serial_oe_out,
  // status
  output logic                              mult_running_out,
  output logic                              sync_active_out
);
  import ser_tx_pkg::*;

  function automatic logic [FRAME_W-1:0] build_frame(input logic [DATA_W-1:0] word);
    build_frame = {CLK_LOW_BIT, word, CLK_HIGH_BIT};
  endfunction : build_frame

  logic [SYNC_W-1:0]  pins;
  logic               tx_clk_prev;
  logic               req_prev;
  logic [DATA_W-1:0]  hold;
  logic [FRAME_W-1:0] shifter;
  logic [3:0]         slot;
  logic [10:0]        sync_left;
  tx_state_t          state;

  logic awake;
  logic cap_edge;
  logic req;
  logic req_rise;
  logic load;
  logic send_sync;
  logic frame_start;

  tx_state_t next_state;

  // synchronised pin levels
  logic               tx_clk;
  logic               edge_rising;
  logic               line_en;
  logic               sync_a;
  logic               sync_b;
  logic [DATA_W-1:0]  data_pins;

  ser_tx_sync2 #(.WIDTH(SYNC_W)) u_sync (
    .clk_in   (sys_clk_in),
    .rst_in   (sys_rst_in),
    .async_in ({sync_request_b_in, sync_request_a_in, sleep_n_in, line_drive_enable_in,
                capture_edge_select_in, transmit_clock_in, parallel_data_in}),
    .sync_out (pins)
  );

  assign tx_clk      = pins[POS_TX_CLK];
  assign edge_rising = pins[POS_EDGE_SEL];
  assign line_en     = pins[POS_LINE_EN];
  assign sync_a      = pins[POS_SYNC_A];
  assign sync_b      = pins[POS_SYNC_B];
  assign data_pins   = pins[POS_DATA +: DATA_W];

  assign awake    = pins[POS_SLEEP_N];
  assign cap_edge = edge_rising ? (tx_clk & ~tx_clk_prev)
                                : (~tx_clk & tx_clk_prev);
  assign req      = sync_a | sync_b;
  assign req_rise = req & ~req_prev;
  assign load     = (state == ST_FRAME) && (slot == LAST_SLOT);
  assign send_sync = req || (sync_left != 11'h000);
  // first frame after wake, or the back-to-back reload at the last slot
  assign frame_start = (state == ST_IDLE && cap_edge) || load;

  // edge history
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_clk_prev <= 1'b0;
      req_prev  <= 1'b0;
    end else begin
      tx_clk_prev <= tx_clk;
      req_prev  <= awake & req;
    end
  end

  // holding register; data is synchronised alongside the clock, so it stays aligned
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hold <= HOLD_RESET;
    end else if (awake && cap_edge) begin
      hold <= data_pins;
    end
  end

  // multiplier state: sleep forces restart, waits for a capture edge to lock
  // sleep wins from every state, so a stuck multiplier is always recoverable
  always_comb begin
    next_state = state;
    case (state)
      ST_SLEEP: begin
        if (awake) next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (!awake) next_state = ST_SLEEP;
        else if (cap_edge) next_state = ST_FRAME;
      end
      ST_FRAME: begin
        if (!awake) next_state = ST_SLEEP;
      end
      default: begin
        next_state = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  // sync burst counter; a new request wins over the countdown
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_left <= 11'h000;
    end else if (!awake) begin
      sync_left <= 11'h000;
    end else if (req_rise) begin
      sync_left <= SYNC_MIN;
    end else if (frame_start && sync_left != 11'h000) begin
      sync_left <= sync_left - 11'h001;
    end
  end

  // frame shifter, one slot per system clock
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shifter <= FRAME_RESET;
      slot    <= 4'h0;
    end else if (!awake) begin
      shifter <= FRAME_RESET;
      slot    <= 4'h0;
    end else if (frame_start) begin
      shifter <= build_frame(send_sync ? SYNC_WORD : hold);
      slot    <= 4'h0;
    end else if (state == ST_FRAME) begin
      shifter <= {1'b0, shifter[FRAME_W-1:1]};
      slot    <= slot + 4'h1;
    end
  end

  // registered pin drive: positive leg
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serial_p_out <= 1'b0;
    end else begin
      serial_p_out <= shifter[0];
    end
  end

  // negative leg; derived from the same flop bit so the pair never skews
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serial_n_out <= 1'b0;
    end else begin
      serial_n_out <= ~shifter[0];
    end
  end

  // pair enable; frames keep running while the line is disabled
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serial_oe_out <= 1'b0;
    end else begin
      serial_oe_out <= awake && line_en && (state == ST_FRAME);
    end
  end

  // multiplier running status
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mult_running_out <= 1'b0;
    end else begin
      mult_running_out <= awake && (state == ST_FRAME);
    end
  end

  // sync selection status for the next frame
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_active_out <= 1'b0;
    end else begin
      sync_active_out <= awake && send_sync;
    end
  end
endmodule : ser_tx_control
`default_nettype wire

// ===== src/ser_tx_sync2.sv
/*
  Two-stage synchroniser for a vector of asynchronous pin levels.
  Assumes each bit is an independent level; no bus coherency.
*/
`timescale 1ns/1ns
`default_nettype none
module ser_tx_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage is read by the second only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ser_tx_sync2
`default_nettype wire

// ===== verif/ser_rx_model.sv
/* Receiving partner: collects 12-slot frames from the serial pair.
   Assumes frames start at slot 0 when the pair turns on. */
`timescale 1ns/1ns
`default_nettype none
module ser_rx_model (
  // clock, reset and serial pair
  input  wire logic   clk_in, rst_in, p_in, n_in, oe_in,
  // received frame
  output logic        frame_out, bad_out,
  output logic [11:0] bits_out
);
  logic [3:0] slot;
  // alignment is lost if the pair turns on mid-frame; any cycle with the pair off realigns it
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) {slot, frame_out, bad_out, bits_out} <= '0;
    else if (!oe_in) {slot, frame_out} <= '0;
    else begin
      bits_out <= {p_in, bits_out[11:1]};
      slot <= (slot == 4'hb) ? 4'h0 : slot + 4'h1;
      frame_out <= slot == 4'hb;
      bad_out <= bad_out | (p_in == n_in);
    end
endmodule : ser_rx_model
`default_nettype wire

// ===== verif/ser_tx_control_asserts.sv
/* Checker for ser_tx_control, bound to its ports.
   Assumes two-flop synchronisers in front of all pin-driven logic. */
`timescale 1ns/1ns
`default_nettype none
module ser_tx_control_asserts (
  // clock, reset and control pins
  input wire logic sys_clk_in, sys_rst_in, line_drive_enable_in, sleep_n_in,
  input wire logic sync_request_a_in, sync_request_b_in,
  // serial pair and status
  input wire logic serial_p_out, serial_n_out, serial_oe_out,
  input wire logic mult_running_out, sync_active_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  int sync_run;
  // length of the current sync burst; a burst of 1024 frames is far beyond 8 repeats
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    if (sys_rst_in) sync_run <= 0;
    else sync_run <= sync_active_out ? sync_run + 1 : 0;
  property p_diff; serial_oe_out |-> serial_n_out == !serial_p_out; endproperty
  a_diff: assert property (p_diff) else $error("pair not complementary");
  property p_sleep; !sleep_n_in [*3] |=> !serial_oe_out && !mult_running_out; endproperty
  a_sleep: assert property (p_sleep) else $error("active while asleep");
  property p_den; !line_drive_enable_in [*3] |=> !serial_oe_out; endproperty
  a_den: assert property (p_den) else $error("pair driven while disabled");
  property p_oe_run; serial_oe_out |-> mult_running_out; endproperty
  a_oe_run: assert property (p_oe_run) else $error("pair driven without frames");
  property p_frame; $rose(mult_running_out) |-> serial_p_out ##11 !serial_p_out ##1 serial_p_out; endproperty
  a_frame: assert property (p_frame) else $error("frame clock bits wrong");
  property p_sync_min; $fell(sync_active_out) && sleep_n_in |-> sync_run >= 12000; endproperty
  a_sync_min: assert property (p_sync_min) else $error("sync burst too short");
  property p_sync_hold; (sleep_n_in && (sync_request_a_in || sync_request_b_in)) [*4] |-> sync_active_out; endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync not selected");
  property p_stop; $fell(mult_running_out) |-> $past(!sleep_n_in, 3); endproperty
  a_stop: assert property (p_stop) else $error("frames stopped without sleep");
  c_wake: cover property ($rose(mult_running_out));
  c_sync_end: cover property ($fell(sync_active_out));
  c_den_off: cover property (mult_running_out && !serial_oe_out);
endmodule : ser_tx_control_asserts
bind ser_tx_control ser_tx_control_asserts chk_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .line_drive_enable_in(line_drive_enable_in), .sleep_n_in(sleep_n_in),
  .sync_request_a_in(sync_request_a_in), .sync_request_b_in(sync_request_b_in),
  .serial_p_out(serial_p_out), .serial_n_out(serial_n_out), .serial_oe_out(serial_oe_out),
  .mult_running_out(mult_running_out), .sync_active_out(sync_active_out));
`default_nettype wire

// ===== verif/tb.sv
/* Bench for ser_tx_control: drives the pins and judges frames via ser_rx_model.
   Assumes a 10 MHz sys clock; the transmit clock is stepped by hand at 400 ns. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ser_tx_pkg::*;
  logic clk = 0, rst = 1, tx_clk = 0, sel = 1, line_en = 1, slp_n = 0, sa = 0, sb = 0;
  logic [9:0] din = '0;
  logic p, n, oe, run, syn, fr, bad;
  logic [11:0] rx;
  int num_errors = 0, check_count = 0;
  always #50 clk = ~clk;
  ser_tx_control dut (.sys_clk_in(clk), .sys_rst_in(rst), .parallel_data_in(din),
    .transmit_clock_in(tx_clk), .capture_edge_select_in(sel), .line_drive_enable_in(line_en),
    .sleep_n_in(slp_n), .sync_request_a_in(sa), .sync_request_b_in(sb), .serial_p_out(p),
    .serial_n_out(n), .serial_oe_out(oe), .mult_running_out(run), .sync_active_out(syn));
  ser_rx_model rx_m (.clk_in(clk), .rst_in(rst), .p_in(p), .n_in(n), .oe_in(oe),
    .frame_out(fr), .bad_out(bad), .bits_out(rx));
  task automatic close_out;
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // next whole frame must be clock-high, word LSB first, clock-low
  task automatic frame(input logic [9:0] d);
    int i;
    // look between edges, where the model's frame flag has settled
    @(negedge clk);
    for (i = 0; i < 40 && fr !== 1'b1; i++) @(negedge clk);
    if (i == 40) num_errors++;
    if (i == 40) close_out();
    chk({CLK_LOW_BIT, d, CLK_HIGH_BIT}, rx);
    @(posedge clk);
  endtask : frame
  // d1 is on the pins at the rise, d2 at the fall
  task automatic t_capture(input logic s, input logic [9:0] d1, d2);
    sel <= s;
    din <= d1;
    cyc(4);
    tx_clk <= 1;
    cyc(4);
    din <= d2;
    tx_clk <= 0;
    cyc(30);
    frame(s ? d1 : d2);
  endtask : t_capture
  task automatic t_sync(input logic which);
    int k;
    if (which) sb <= 1;
    else sa <= 1;
    cyc(30);
    frame(SYNC_WORD);
    sa <= 0;
    sb <= 0;
    for (k = 0; k < 14000 && syn !== 1'b0; k++) @(negedge clk);
    if (k == 14000) num_errors++;
    if (k == 14000) close_out();
    chk({10'h0, syn, k > 12000}, 12'h1);
    @(posedge clk);
    cyc(14);
    frame(10'h03c);
  endtask : t_sync
  initial begin
    cyc(16);
    rst <= 0;
    slp_n <= 1;
    cyc(4);
    t_capture(1, 10'h2a5, 10'h15a);
    t_capture(0, 10'h3c3, 10'h03c);
    t_sync(0);
    t_sync(1);
    line_en <= 0;
    cyc(5);
    chk({10'h0, oe, run}, 12'h1);
    line_en <= 1;
    slp_n <= 0;
    cyc(5);
    chk({10'h0, oe, run}, 12'h0);
    slp_n <= 1;
    cyc(5);
    t_capture(1, 10'h155, 10'h0aa);
    chk({11'h0, bad}, 12'h0);
    close_out();
  end
endmodule : tb
`default_nettype wire
